// ==== rtl/autoneg_status_defs.vh ====
// constants for the auto-negotiation status register bank
// ==========================================================
`ifndef AUTONEG_STATUS_DEFS_VH
`define AUTONEG_STATUS_DEFS_VH

// register indices, byte address is four times the index
`define REG_IDX_STATUS      8'h01
`define REG_IDX_PARTNER     8'h05
`define REG_IDX_EXPANSION   8'h06
`define REG_IDX_CONTROL     8'h10
`define APB_ADDR_W          10

// arbitration state codes presented by the arbitration machine
`define ARB_TRANSMIT_DISABLE 4'h0
`define ARB_ABILITY_DETECT   4'h1
`define ARB_ACK_DETECT       4'h2
`define ARB_COMPLETE_ACK     4'h3
`define ARB_NEXT_PAGE_WAIT   4'h4
`define ARB_LINK_CHECK       4'h5
`define ARB_PD_FAULT         4'h6
`define ARB_LINK_GOOD_CHECK  4'h7
`define ARB_FLP_LINK_GOOD    4'h8
`define ARB_RESET_STATE      4'hF

// status register fields
`define ST_BIT_LINK          2
`define ST_BIT_AN_ABLE       3
`define ST_BIT_RFAULT        4
`define ST_BIT_AN_DONE       5

// expansion register fields
`define EX_BIT_LP_AN_ABLE    0
`define EX_BIT_PAGE_RX       1
`define EX_BIT_NP_ABLE       2
`define EX_BIT_LP_NP_ABLE    3
`define EX_BIT_PD_FAULT      4

// codeword fields
`define CW_BIT_RFAULT        13
`define CW_BIT_NP            15

// control register fields and reset value
`define CTL_BIT_PD_EN        0
`define CTL_RESET            1'b1

// codewords loaded after parallel detection of a legacy link
`define PD_WORD_10T          16'h0021
`define PD_WORD_100TX        16'h0081
`define PD_WORD_100T4        16'h0201

// parallel detection wait timer
`define AN_WAIT_MS           500
`define CLK_KHZ              25000
`define AN_WAIT_CYCLES       (`AN_WAIT_MS * `CLK_KHZ)

`endif

// ==== rtl/parallel_detect_monitor.v ====
// parallel detection window timer and fault / technology decision
`default_nettype none
`include "autoneg_status_defs.vh"

module parallel_detect_monitor #(
  parameter WAIT_CYCLES = `AN_WAIT_CYCLES,
  parameter CNT_W       = 24
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // control
  input  wire        enable,
  input  wire        start,
  input  wire        inCheck,
  // per PMA link ready: 0 10T, 1 100TX, 2 100T4
  input  wire [2:0]  pmaReady,
  // results
  output reg         faultPulse,
  output reg         loadPulse,
  output reg  [15:0] techWord
);

  reg             active_q;
  reg [CNT_W-1:0] count_q;
  wire            expired;
  wire            multi;
  wire            none;

  assign expired = (count_q == WAIT_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});
  assign multi   = (pmaReady[0] & pmaReady[1]) | (pmaReady[0] & pmaReady[2]) | (pmaReady[1] & pmaReady[2]);
  assign none    = ~(|pmaReady);

  // window runs from start until timer expiry, a multiple-ready fault, state exit or disable
  always @(posedge clk) begin
    faultPulse <= 1'b0;
    loadPulse  <= 1'b0;
    if (rst) begin
      active_q <= 1'b0;
      count_q  <= {CNT_W{1'b0}};
      techWord <= 16'h0000;
    end else if (start && enable) begin
      active_q <= 1'b1;
      count_q  <= {CNT_W{1'b0}};
    end else if (active_q && (!inCheck || !enable)) begin
      active_q <= 1'b0;
    end else if (active_q) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
      if (multi) begin
        faultPulse <= 1'b1;
        active_q   <= 1'b0;
      end else if (expired) begin
        active_q <= 1'b0;
        if (none) begin
          faultPulse <= 1'b1;
        end else begin
          loadPulse <= 1'b1;
          if (pmaReady[0]) begin
            techWord <= `PD_WORD_10T;
          end else if (pmaReady[1]) begin
            techWord <= `PD_WORD_100TX;
          end else begin
            techWord <= `PD_WORD_100T4;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/autoneg_status_registers.v ====
// management status registers of the auto-negotiation unit over APB
//
// Register access over APB was left to the implementer.
`default_nettype none
`include "autoneg_status_defs.vh"

module autoneg_status_registers #(
  parameter        WAIT_CYCLES   = `AN_WAIT_CYCLES,
  parameter [4:0]  ABILITY_BITS  = 5'h0F,
  parameter        LOCAL_NP_ABLE = 1
) (
  // clock and reset
  input  wire                   clk,
  input  wire                   rst,
  // apb slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`APB_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output wire                   pready,
  output reg  [31:0]            prdata,
  output wire                   pslverr,
  // arbitration machine view
  input  wire [3:0]             arbState,
  input  wire [15:0]            rxCodeword,
  input  wire                   linkStatus,
  input  wire [2:0]             pmaReady
);

  // ==========================================================
  // state tracking
  reg  [3:0]  prevState_q;
  wire        enterAbility;
  wire        enterAckDetect;
  wire        enterCompleteAck;
  wire        enterLinkGood;
  wire        enterLinkCheck;

  // entry means the state differs from the one seen a cycle ago; the
  // reset code matches no real state, so the state present when reset
  // lifts counts as entered
  always @(posedge clk) begin
    if (rst) begin
      prevState_q <= `ARB_RESET_STATE;
    end else begin
      prevState_q <= arbState;
    end
  end

  assign enterAbility     = (arbState == `ARB_ABILITY_DETECT) && (prevState_q != `ARB_ABILITY_DETECT);
  assign enterAckDetect   = (arbState == `ARB_ACK_DETECT) && (prevState_q != `ARB_ACK_DETECT);
  assign enterCompleteAck = (arbState == `ARB_COMPLETE_ACK) && (prevState_q != `ARB_COMPLETE_ACK);
  assign enterLinkGood    = (arbState == `ARB_FLP_LINK_GOOD) && (prevState_q != `ARB_FLP_LINK_GOOD);
  assign enterLinkCheck   = (arbState == `ARB_LINK_CHECK) && (prevState_q != `ARB_LINK_CHECK);

  // ==========================================================
  // apb decode
  wire [7:0]  regIdx;
  wire        wordAligned;
  wire        hitStatus;
  wire        hitPartner;
  wire        hitExpansion;
  wire        hitControl;
  wire        mapped;
  wire        setupPhase;
  wire        accessDone;
  wire        readDone;
  wire        writeDone;
  wire        readStatus;
  wire        readExpansion;

  // one 16-bit register sits in the low half of each aligned word:
  //   index 0x01 status, 0x05 partner ability (read only),
  //   index 0x06 expansion, 0x10 parallel detection control;
  // anything else, or an unaligned address, answers with pslverr
  assign regIdx       = paddr[9:2];
  assign wordAligned  = (paddr[1:0] == 2'b00);
  assign hitStatus    = wordAligned && (regIdx == `REG_IDX_STATUS);
  assign hitPartner   = wordAligned && (regIdx == `REG_IDX_PARTNER);
  assign hitExpansion = wordAligned && (regIdx == `REG_IDX_EXPANSION);
  assign hitControl   = wordAligned && (regIdx == `REG_IDX_CONTROL);
  assign mapped       = hitStatus | hitPartner | hitExpansion | hitControl;

  // zero wait state slave: every access phase completes at once
  assign pready        = 1'b1;
  assign setupPhase    = psel & ~penable;
  assign accessDone    = psel & penable;
  assign readDone      = accessDone & ~pwrite & mapped;
  assign writeDone     = accessDone & pwrite & mapped;
  assign pslverr       = accessDone & ~mapped;
  assign readStatus    = readDone & hitStatus;
  assign readExpansion = readDone & hitExpansion;

  // ==========================================================
  // flags that the read in progress has already put on the bus
  wire        rfReported;
  wire        pdFaultReported;
  wire        pageRxReported;

  // prdata still holds the word loaded at the setup edge, so a read clears
  // only what it returned; a set landing on that setup edge stays latched
  assign rfReported      = readStatus & prdata[`ST_BIT_RFAULT];
  assign pdFaultReported = readExpansion & prdata[`EX_BIT_PD_FAULT];
  assign pageRxReported  = readExpansion & prdata[`EX_BIT_PAGE_RX];

  // ==========================================================
  // control register, the only writable one
  reg         pdEnable_q;

  // writes elsewhere, partner ability included, are dropped
  always @(posedge clk) begin
    if (rst) begin
      pdEnable_q <= `CTL_RESET;
    end else if (writeDone && hitControl) begin
      pdEnable_q <= pwdata[`CTL_BIT_PD_EN];
    end
  end

  // ==========================================================
  // parallel detection
  wire        pdFaultEvt;
  wire        pdLoadEvt;
  wire [15:0] pdTechWord;
  wire        inLinkCheck;

  // smallest counter width that still reaches the last window cycle
  function integer widthFor;
    input integer count;
    integer rest;
    begin
      widthFor = 1;
      rest     = count - 1;
      while (rest > 1) begin
        rest     = rest >> 1;
        widthFor = widthFor + 1;
      end
    end
  endfunction

  localparam PD_CNT_W = widthFor(WAIT_CYCLES);

  // the window only runs while the arbitration sits in link check
  assign inLinkCheck = (arbState == `ARB_LINK_CHECK);

  parallel_detect_monitor #(
    .WAIT_CYCLES (WAIT_CYCLES),
    .CNT_W       (PD_CNT_W)
  ) u_pd (
    .clk        (clk),
    .rst        (rst),
    .enable     (pdEnable_q),
    .start      (enterLinkCheck),
    .inCheck    (inLinkCheck),
    .pmaReady   (pmaReady),
    .faultPulse (pdFaultEvt),
    .loadPulse  (pdLoadEvt),
    .techWord   (pdTechWord)
  );

  // ==========================================================
  // partner ability capture
  reg  [15:0] lpAbility_q;
  reg         basePage_q;
  reg         lpNpAble_q;
  wire        baseRx;

  assign baseRx = enterCompleteAck & basePage_q;

  // first page after ability detect is the base page
  always @(posedge clk) begin
    if (rst) begin
      basePage_q <= 1'b1;
    end else if (enterAbility) begin
      basePage_q <= 1'b1;
    end else if (enterCompleteAck) begin
      basePage_q <= 1'b0;
    end
  end

  // every received page lands here on the same edge that page received rises
  always @(posedge clk) begin
    if (rst) begin
      lpAbility_q <= 16'h0000;
      lpNpAble_q  <= 1'b0;
    end else if (enterCompleteAck) begin
      lpAbility_q <= rxCodeword;
      if (baseRx) begin
        lpNpAble_q <= rxCodeword[`CW_BIT_NP];
      end
    end else if (pdLoadEvt) begin
      lpAbility_q <= pdTechWord;
      lpNpAble_q  <= 1'b0;
    end
  end

  // ==========================================================
  // latched flags: set wins over clear-on-read
  reg         remoteFault_q;
  reg         pdFault_q;
  reg         pageRx_q;
  reg         lpAnAble_q;
  wire        rfSet;
  wire        rfClear;

  // only the base page carries a remote fault; a link, or a read that
  // returned the bit, drops it again
  assign rfSet   = baseRx & rxCodeword[`CW_BIT_RFAULT];
  assign rfClear = rfReported | enterLinkGood;

  // remote fault flag, set wins over a clear in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      remoteFault_q <= 1'b0;
    end else if (rfSet) begin
      remoteFault_q <= 1'b1;
    end else if (rfClear) begin
      remoteFault_q <= 1'b0;
    end
  end

  // parallel detection fault
  always @(posedge clk) begin
    if (rst) begin
      pdFault_q <= 1'b0;
    end else if (pdFaultEvt) begin
      pdFault_q <= 1'b1;
    end else if (pdFaultReported) begin
      pdFault_q <= 1'b0;
    end
  end

  // page received
  always @(posedge clk) begin
    if (rst) begin
      pageRx_q <= 1'b0;
    end else if (enterCompleteAck) begin
      pageRx_q <= 1'b1;
    end else if (enterAckDetect || pageRxReported) begin
      pageRx_q <= 1'b0;
    end
  end

  // link partner is auto-negotiation able
  always @(posedge clk) begin
    if (rst) begin
      lpAnAble_q <= 1'b0;
    end else if (enterAckDetect) begin
      lpAnAble_q <= 1'b1;
    end else if (enterAbility) begin
      lpAnAble_q <= 1'b0;
    end
  end

  // ==========================================================
  // read data
  reg  [15:0] statusWord;
  reg  [15:0] expansionWord;
  reg  [15:0] readWord;

  // status word from the live flags and pins
  always @* begin
    statusWord                   = 16'h0000;
    statusWord[15:11]            = ABILITY_BITS;
    statusWord[`ST_BIT_AN_DONE]  = (arbState == `ARB_FLP_LINK_GOOD);
    statusWord[`ST_BIT_RFAULT]   = remoteFault_q;
    statusWord[`ST_BIT_AN_ABLE]  = 1'b1;
    statusWord[`ST_BIT_LINK]     = linkStatus;
  end

  // expansion word; page received stays hidden in acknowledge detect
  always @* begin
    expansionWord                     = 16'h0000;
    expansionWord[`EX_BIT_PD_FAULT]   = pdFault_q;
    expansionWord[`EX_BIT_LP_NP_ABLE] = lpNpAble_q;
    expansionWord[`EX_BIT_NP_ABLE]    = (LOCAL_NP_ABLE != 0);
    expansionWord[`EX_BIT_PAGE_RX]    = pageRx_q & (arbState != `ARB_ACK_DETECT);
    expansionWord[`EX_BIT_LP_AN_ABLE] = lpAnAble_q;
  end

  // word of the addressed register
  always @* begin
    readWord = 16'h0000;
    if (hitStatus) begin
      readWord = statusWord;
    end else if (hitPartner) begin
      readWord = lpAbility_q;
    end else if (hitExpansion) begin
      readWord = expansionWord;
    end else if (hitControl) begin
      readWord = {15'h0000, pdEnable_q};
    end
  end

  // read data is sampled in the setup cycle, before any clear, and
  // stands through the access cycle until the next read setup
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setupPhase && !pwrite) begin
      prdata <= {16'h0000, readWord};
    end
  end

endmodule
`default_nettype wire

// ==== tb/autoneg_status_registers_properties.sv ====
// port assertions for the auto-negotiation status register bank
`default_nettype none
`include "autoneg_status_defs.vh"
module autoneg_status_checker #(
  parameter [4:0] ABILITY_BITS  = 5'h0F,
  parameter       LOCAL_NP_ABLE = 1
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst,
  // apb slave side
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  // arbitration view
  input wire logic [3:0]             arbState,
  input wire logic [15:0]            rxCodeword,
  input wire logic                   linkStatus
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // sequences and checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // read setup cycle at one byte address
  sequence rdSetup(logic [9:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  // first cycle of complete acknowledge
  sequence cplEntry;
    arbState == `ARB_COMPLETE_ACK && $past(arbState) != `ARB_COMPLETE_ACK;
  endsequence
  a_ready_access: assert property (psel && penable |-> pready) else $error("no ready in access");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_err_unmapped: assert property (psel && penable && paddr == 10'h3FC |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_status_live: assert property (rdSetup(10'h004) |=> prdata == {16'h0, ABILITY_BITS, 5'h0,
    $past(arbState) == `ARB_FLP_LINK_GOOD, prdata[4], 1'b1, $past(linkStatus), 2'b0}) else $error("status bad");
  a_page_capture: assert property (cplEntry ##1 rdSetup(10'h014) |=> prdata == {16'h0, $past(rxCodeword, 2)})
    else $error("page not captured");
  a_page_flag: assert property (cplEntry ##1 rdSetup(10'h018) |=> prdata[1]) else $error("page flag missing");
  a_ackdet_mask: assert property (rdSetup(10'h018) ##0 (arbState == `ARB_ACK_DETECT
    && $past(arbState) == `ARB_ACK_DETECT) |=> prdata[1:0] == 2'b01) else $error("ack detect flags bad");
  a_np_able: assert property (rdSetup(10'h018) |=> prdata[2] == (LOCAL_NP_ABLE != 0)) else $error("np able bad");
  a_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
endmodule
bind autoneg_status_registers autoneg_status_checker #(.ABILITY_BITS(ABILITY_BITS), .LOCAL_NP_ABLE(LOCAL_NP_ABLE)) props (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .arbState(arbState), .rxCodeword(rxCodeword), .linkStatus(linkStatus));
`default_nettype wire

// ==== tb/link_partner_model.sv ====
// link partner and arbitration side model driving the state view
`default_nettype none
`include "autoneg_status_defs.vh"
module link_partner_model (
  // clock
  input  wire logic       clk,
  // arbitration view
  output var logic [3:0]  arbState,
  output var logic [15:0] rxCodeword,
  output var logic        linkStatus,
  output var logic [2:0]  pmaReady
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // idle line values
  initial begin
    arbState = `ARB_TRANSMIT_DISABLE;
    rxCodeword = 16'h0000;
    linkStatus = 1'b0;
    pmaReady = 3'h0;
  end
  // step to a state; the page is only valid in complete ack, else it toggles
  task automatic go(input logic [3:0] s, input logic [15:0] cw, input logic [2:0] rdy);
    @(posedge clk);
    arbState <= s;
    rxCodeword <= (s == `ARB_COMPLETE_ACK) ? cw : ~rxCodeword;
    linkStatus <= (s == `ARB_FLP_LINK_GOOD);
    pmaReady <= rdy;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_autoneg_status_registers.sv ====
// self-checking bench for the auto-negotiation status registers
`default_nettype none
`include "autoneg_status_defs.vh"
module tb_autoneg_status_registers;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] ST = {`REG_IDX_STATUS, 2'b00}, PA = {`REG_IDX_PARTNER, 2'b00}, EX = {`REG_IDX_EXPANSION, 2'b00};
  localparam logic [9:0] CT = {`REG_IDX_CONTROL, 2'b00};
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, linkStatus, err;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'hE333;
  logic [3:0]  arbState;
  logic [15:0] rxCodeword, cw;
  logic [2:0]  pmaReady;
  int          errors = 0, n_checks = 0;
  // ====================
  // clock, design and partner
  always #20 clk = ~clk;
  autoneg_status_registers #(.WAIT_CYCLES(20)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .arbState(arbState), .rxCodeword(rxCodeword), .linkStatus(linkStatus), .pmaReady(pmaReady));
  link_partner_model lp (.clk(clk), .arbState(arbState), .rxCodeword(rxCodeword), .linkStatus(linkStatus),
    .pmaReady(pmaReady));
  // expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] stExp(input logic rf, input logic lg);
    return {16'h0, 5'h0F, 5'h00, lg, rf, 1'b1, lg, 2'b00};
  endfunction
  function automatic logic [16:0] pdExp(input logic [2:0] r);
    case (r)
      3'h1: return {1'b0, `PD_WORD_10T};
      3'h2: return {1'b0, `PD_WORD_100TX};
      3'h4: return {1'b0, `PD_WORD_100T4};
      default: return {1'b1, 16'h0000};
    endcase
  endfunction
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer, waits on pready with a bound
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    if (n >= 100) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  // main sequence
  initial begin
    logic [16:0] pe;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(0, ST, 0); check("status reset", stExp(0, 0), rd);
    apb(0, EX, 0); check("expansion reset", 32'h4, rd);
    apb(0, 10'h3FC, 0); check("unmapped error", 32'h1, {31'h0, err});
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      cw = (i == 0) ? 16'h41E1 : (i == 1) ? 16'hFFFF : (i == 2) ? 16'h4101 : rnd[15:0];
      lp.go(`ARB_ABILITY_DETECT, 0, 0);
      apb(0, EX, 0); check("able cleared", 32'h0, {31'h0, rd[0]});
      lp.go(`ARB_ACK_DETECT, 0, 0);
      apb(0, EX, 0); check("ackdet flags", 32'h1, {30'h0, rd[1:0]});
      lp.go(`ARB_COMPLETE_ACK, cw, 0);
      apb(0, PA, 0); check("partner page", {16'h0, cw}, rd);
      apb(0, EX, 0); check("page flag", {28'h0, cw[15], 3'b111}, {28'h0, rd[3:0]});
      apb(0, EX, 0); check("page flag cleared", 32'h0, {31'h0, rd[1]});
      apb(0, ST, 0); check("remote fault", stExp(cw[13], 0), rd);
      apb(0, ST, 0); check("remote fault read", stExp(0, 0), rd);
      apb(1, PA, 32'hFFFF); apb(0, PA, 0); check("partner ro", {16'h0, cw}, rd);
      lp.go(`ARB_ACK_DETECT, 0, 0);
      apb(0, EX, 0); check("np ackdet", 32'h1, {30'h0, rd[1:0]});
      lp.go(`ARB_COMPLETE_ACK, ~cw, 0);
      apb(0, EX, 0); check("np flag", 32'h1, {31'h0, rd[1]});
      apb(0, PA, 0); check("np stored", {16'h0, ~cw}, rd);
      apb(0, ST, 0); check("np no fault", stExp(0, 0), rd);
    end
    // corner: page arrives on the very setup edge of an expansion read
    lp.go(`ARB_ACK_DETECT, 0, 0);
    fork
      lp.go(`ARB_COMPLETE_ACK, 16'h0001, 0);
      apb(0, EX, 0);
    join
    check("page rx same edge", 32'h0, {31'h0, rd[1]});
    apb(0, EX, 0); check("page rx kept", 32'h1, {31'h0, rd[1]});
    lp.go(`ARB_ABILITY_DETECT, 0, 0);
    lp.go(`ARB_ACK_DETECT, 0, 0);
    lp.go(`ARB_COMPLETE_ACK, 16'h2000, 0);
    lp.go(`ARB_FLP_LINK_GOOD, 0, 0);
    apb(0, ST, 0); check("link clears fault", stExp(0, 1), rd);
    apb(0, PA, 0); check("partner at link", {16'h0, 16'h2000}, rd);
    for (int i = 0; i < 8; i++) begin
      pe = pdExp(i[2:0]);
      lp.go(`ARB_LINK_CHECK, 0, i[2:0]);
      repeat (25) @(posedge clk);
      lp.go(`ARB_TRANSMIT_DISABLE, 0, 0);
      apb(0, EX, 0); check("pd fault", {31'h0, pe[16]}, {31'h0, rd[4]});
      apb(0, EX, 0); check("pd fault cleared", 32'h0, {31'h0, rd[4]});
      apb(0, PA, 0);
      if (!pe[16]) check("pd word", {16'h0, pe[15:0]}, rd);
    end
    // parallel detection switched off: no window, so no fault
    apb(1, CT, 0); apb(0, CT, 0); check("pd enable off", 32'h0, rd);
    lp.go(`ARB_LINK_CHECK, 0, 0);
    repeat (25) @(posedge clk);
    lp.go(`ARB_TRANSMIT_DISABLE, 0, 0);
    apb(0, EX, 0); check("pd disabled", 32'h0, {31'h0, rd[4]});
    apb(1, CT, 1); apb(0, CT, 0); check("pd enable on", 32'h1, rd);
    finish_test();
  end
endmodule
`default_nettype wire
